// [core/dct_pkg.sv]
/*
 * Constants shared by the dual channel down timer: register offsets, field positions,
 * reset values, channel states and the fixed pipeline depths of the counting logic.
 * Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address window.
 */
package dct_pkg;
	// Number of independent down-counting channels in one timer.
	localparam int NUM_CH = 2;

	// Register byte offsets. Offsets not listed here, other than the channel 1 registers, answer with SLVERR.
	localparam logic [11:0] OFF_CLK_ON  = 12'h050; // Power manager clock enable, write-only.
	localparam logic [11:0] OFF_CLK_OFF = 12'h054; // Power manager clock disable, write-only.
	localparam logic [11:0] OFF_PMSR    = 12'h058; // Timer clock status, read-only.
	localparam logic [11:0] OFF_CTRL    = 12'h060; // timer_control_reg, write-only.
	localparam logic [11:0] OFF_CLR     = 12'h06C; // flag_clear_reg, write-only.
	localparam logic [11:0] OFF_STAT    = 12'h070; // timer_status_reg, read-only.
	localparam logic [11:0] OFF_IEN     = 12'h074; // irq_unmask_reg, write-only set.
	localparam logic [11:0] OFF_IDIS    = 12'h078; // Interrupt mask clear, write-only.
	localparam logic [11:0] OFF_IMASK   = 12'h07C; // Interrupt mask readback.
	localparam logic [11:0] OFF_DIV0    = 12'h080; // channel_divider_reg of channel 0.
	localparam logic [11:0] OFF_CNT0    = 12'h084; // channel_count_reg of channel 0.
	localparam logic [11:0] OFF_CH_STEP = 12'h008; // Distance between channel register pairs.
	localparam logic [11:0] OFF_LIVE0   = 12'h200; // live_count_reg of channel 0.
	localparam logic [11:0] OFF_LIVE_STEP = 12'h004; // Distance between live count registers.

	// Power manager clock bit, same position in enable, disable and status.
	localparam int PM_CLK_BIT = 1;

	// timer_control_reg bits: restart, then one on and one off command per channel.
	localparam int CR_RESTART_BIT = 0;
	localparam int CR_ON_BIT0     = 1;
	localparam int CR_OFF_BIT0    = 2;
	localparam int CR_CH_STEP     = 2;

	// Status, clear and mask layout: three flags per channel; status also has on flags up high.
	localparam int SR_DONE_BIT0 = 0;
	localparam int SR_OFF_BIT0  = 1;
	localparam int SR_BEGAN_BIT0 = 2;
	localparam int SR_CH_STEP   = 3;
	localparam int SR_FLAGS     = 6;
	localparam int SR_ON_BIT0   = 24;

	// channel_divider_reg fields.
	localparam int PR_SECOND_LSB = 0;  // Second stage divide exponent, 4 bits.
	localparam int PR_FIRST_LSB  = 4;  // first_stage_divide exponent, 4 bits.
	localparam int PR_SRC_BIT    = 8;  // divider_source_sel, 0 selects the core clock.
	localparam int PR_RELOAD_BIT = 9;  // reload_on_zero.
	localparam int PR_WIDTH      = 10;

	// Reset values.
	localparam logic [PR_WIDTH-1:0] PR_RESET   = 10'h000;
	localparam logic [15:0]         CNT_RESET  = 16'h0000;
	localparam logic [SR_FLAGS-1:0] MASK_RESET = 6'h00;

	// Staging depth of on and off commands into the counting logic.
	localparam int SYNC_STAGES = 2;
	// Core clock cycles from the counter reaching zero to the done flag.
	localparam int DONE_DELAY  = 3;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Channel run state.
	typedef enum logic {
		DCT_CH_IDLE,
		DCT_CH_RUN
	} dct_ch_state_t;
endpackage

// [core/dct_timer.sv]
/*
 * Dual channel down timer with an AXI4-Lite register slave and one interrupt line.
 * Each channel has a two stage divider fed by the core clock or by the slow auxiliary
 * clock, and a 16-bit down counter with optional reload.
 * Assumes slow_aux_clock is a free running pin slower than half of ref_clk; it is
 * synchronised here and only its rising edges are used.
 */
// Functional notes
// (R01) Two channels, two dividers, 16-bit counter.
// (R02) Per channel choice of core or slow clock.
// (R03) Nonzero load counts down, event at zero.
// (R04) Load to event equals count times period.
// (R05) Software waits for on or off status.
// (R06) Count register write ignored while channel runs.
// (R07) Disabled channel keeps count and resumes.
// (R08) Core clock passes first then second divider.
// (R09) Slow clock passes second divider only.
// (R10) Reload on zero restores programmed start value.
// (R11) Live count readable per channel.
// (R12) Events: disabled, loaded and started, done.
// (R13) Done flag three core cycles after zero.
// (R14) Gated clock freezes timer, resumes exactly.
// (R15) First divides by 2^(f+1), second 2^s.
// (R16) Source select zero picks the core clock.
// (R17) Software waits after restart before configuring.
// (R18) Loaded flag set when value enters counter.
// (R19) On flag set once the channel runs.
// (R20) Software reads status, clears via clear register.
// (R21) Unmask bit lets done event interrupt.
// (R22) On and off together leave channel off.
// (R23) Restart returns all timer registers to reset; power manager gate kept.
// (R24) Off flag means divider reset after delay.
// (R25) Interrupt when any unmasked flag is set.
// (R26) Commands staged safely into counting logic.
`timescale 1ns/1ps
module dct_timer (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        slow_aux_clock,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	localparam int N = dct_pkg::NUM_CH;

	// Bus handshake and interrupt registers; every bus output is one of these flip-flops.
	logic        aw_rdy_reg;   // Pulses for one cycle while address and data are taken.
	logic        bvalid_reg;   // Write response pending.
	logic [1:0]  bresp_reg;    // Write response code.
	logic        ar_rdy_reg;   // Pulses for one cycle while a read address is taken.
	logic        rvalid_reg;   // Read data pending.
	logic [1:0]  rresp_reg;    // Read response code.
	logic [31:0] rdata_reg;    // Read data.
	logic        irq_reg;      // Interrupt request.

	// Timer wide state.
	logic                        clk_on_reg;  // Power manager gate, survives soft restart.
	logic [dct_pkg::SR_FLAGS-1:0] mask_reg;   // Interrupt mask.
	logic [2:0]                  aux_sync_reg; // Slow clock synchroniser and edge history.

	// Per channel values published by the generate loop.
	logic [15:0]                  ch_live  [N];
	logic [15:0]                  ch_load  [N];
	logic [dct_pkg::PR_WIDTH-1:0] ch_div   [N];
	logic [N-1:0]                 ch_on;
	logic [dct_pkg::SR_FLAGS-1:0] flags;

	// A write is performed in the cycle in which address and data are taken together.
	wire        wr_go   = aw_rdy_reg;
	wire [11:0] wa      = s_axi_awaddr;
	wire [31:0] wd      = s_axi_wdata & {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
	                                     {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
	wire        wr_ctrl = wr_go && (wa == dct_pkg::OFF_CTRL);
	wire        wr_clr  = wr_go && (wa == dct_pkg::OFF_CLR);
	wire        wr_ien  = wr_go && (wa == dct_pkg::OFF_IEN);
	wire        wr_idis = wr_go && (wa == dct_pkg::OFF_IDIS);
	wire        wr_pon  = wr_go && (wa == dct_pkg::OFF_CLK_ON);
	wire        wr_poff = wr_go && (wa == dct_pkg::OFF_CLK_OFF);
	// Soft restart resets everything except the power manager gate.
	wire        soft_rst = wr_ctrl && wd[dct_pkg::CR_RESTART_BIT]; // see (R23)
	wire        aux_rise = aux_sync_reg[1] && !aux_sync_reg[2];
	wire [dct_pkg::SR_FLAGS-1:0] clr_bits = wr_clr ? wd[dct_pkg::SR_FLAGS-1:0] : '0;

	// Read and write decode of the per channel registers, driven by the generate loop.
	wire [N-1:0] wr_div;
	wire [N-1:0] wr_cnt;
	wire [N-1:0] wa_div_hit;
	wire [N-1:0] wa_cnt_hit;
	wire [N-1:0] ra_div_hit;
	wire [N-1:0] ra_cnt_hit;
	wire [N-1:0] ra_live_hit;

	// Channel logic, one copy per channel.
	for (genvar z = 0; z < N; z++) begin : g_ch
		localparam logic [11:0] DIV_A  = 12'(dct_pkg::OFF_DIV0 + z * dct_pkg::OFF_CH_STEP);
		localparam logic [11:0] CNT_A  = 12'(dct_pkg::OFF_CNT0 + z * dct_pkg::OFF_CH_STEP);
		localparam logic [11:0] LIVE_A = 12'(dct_pkg::OFF_LIVE0 + z * dct_pkg::OFF_LIVE_STEP);
		localparam int ON_B  = dct_pkg::CR_ON_BIT0 + z * dct_pkg::CR_CH_STEP;
		localparam int OFF_B = dct_pkg::CR_OFF_BIT0 + z * dct_pkg::CR_CH_STEP;
		localparam int DONE_F  = dct_pkg::SR_DONE_BIT0 + z * dct_pkg::SR_CH_STEP;
		localparam int OFF_F   = dct_pkg::SR_OFF_BIT0 + z * dct_pkg::SR_CH_STEP;
		localparam int BEGAN_F = dct_pkg::SR_BEGAN_BIT0 + z * dct_pkg::SR_CH_STEP;

		dct_pkg::dct_ch_state_t    state_reg;    // Run state of the channel.
		logic [dct_pkg::PR_WIDTH-1:0] div_reg;   // Divider configuration.
		logic [15:0]               load_reg;     // Programmed start value.
		logic                      pend_reg;     // A new start value waits to be loaded.
		logic [15:0]               live_reg;     // Down counter.
		logic [15:0]               first_reg;    // First stage divider count.
		logic [14:0]               second_reg;   // Second stage divider count.
		logic [dct_pkg::SYNC_STAGES-1:0] on_pipe_reg;  // Staged on command.
		logic [dct_pkg::SYNC_STAGES-1:0] off_pipe_reg; // Staged off command.
		logic [dct_pkg::DONE_DELAY-1:0]  done_pipe_reg; // Zero hit on its way to the flag.
		logic                      done_reg;     // count_done_flag.
		logic                      off_reg;      // Channel off flag.
		logic                      began_reg;    // count_began_flag.
		logic                      on_reg;       // channel_on_flag.

		// Off wins when both commands arrive in one write.
		wire on_req  = wr_ctrl && wd[ON_B] && !wd[OFF_B]; // see (R22)
		wire off_req = wr_ctrl && wd[OFF_B];              // see (R22)
		wire on_take  = clk_on_reg && on_pipe_reg[dct_pkg::SYNC_STAGES-1];
		wire off_take = clk_on_reg && off_pipe_reg[dct_pkg::SYNC_STAGES-1];

		wire       src_slow = div_reg[dct_pkg::PR_SRC_BIT];          // see (R16)
		wire       reload   = div_reg[dct_pkg::PR_RELOAD_BIT];
		wire [3:0] f_exp    = div_reg[dct_pkg::PR_FIRST_LSB +: 4];
		wire [3:0] s_exp    = div_reg[dct_pkg::PR_SECOND_LSB +: 4];
		// Low-bit masks: the first stage spans f+1 bits, the second s bits.
		wire [15:0] f_mask  = ~(16'hFFFE << f_exp);                  // see (R15)
		wire [14:0] s_mask  = ~(15'h7FFF << s_exp);                  // see (R15)
		// Counting needs the gate open, the channel running and a nonzero count.
		wire active   = clk_on_reg && (state_reg == dct_pkg::DCT_CH_RUN)
		                && (live_reg != 16'h0000);                   // see (R03) (R14)
		wire f_tick   = (first_reg & f_mask) == f_mask;              // see (R08)
		wire s_in     = src_slow ? aux_rise : f_tick;                // see (R02) (R09)
		wire ch_tick  = active && s_in && ((second_reg & s_mask) == s_mask); // see (R01)
		wire zero_hit = ch_tick && (live_reg == 16'h0001);           // see (R04)

		assign wa_div_hit[z]  = (wa == DIV_A);
		assign wa_cnt_hit[z]  = (wa == CNT_A);
		assign ra_div_hit[z]  = (s_axi_araddr == DIV_A);
		assign ra_cnt_hit[z]  = (s_axi_araddr == CNT_A);
		assign ra_live_hit[z] = (s_axi_araddr == LIVE_A);
		assign wr_div[z] = wr_go && wa_div_hit[z];
		// The start value is frozen while the channel runs.
		assign wr_cnt[z] = wr_go && wa_cnt_hit[z]
		                   && (state_reg == dct_pkg::DCT_CH_IDLE);   // see (R06)
		assign ch_live[z] = live_reg;                                // see (R11)
		assign ch_load[z] = load_reg;
		assign ch_div[z]  = div_reg;
		assign ch_on[z]   = on_reg;
		assign flags[DONE_F]  = done_reg;
		assign flags[OFF_F]   = off_reg;
		assign flags[BEGAN_F] = began_reg;

		// Command staging. While the gate is shut the stages hold and gather new requests,
		// so a command written during a gated period is carried out on resumption.
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				on_pipe_reg  <= '0;
				off_pipe_reg <= '0;
			end else if (soft_rst || off_req) begin
				on_pipe_reg  <= '0;                  // An off command cancels a staged on.
				off_pipe_reg <= soft_rst ? '0 : {off_pipe_reg[0 +: dct_pkg::SYNC_STAGES-1],
				                                 1'b1};
			end else if (clk_on_reg) begin
				on_pipe_reg  <= {on_pipe_reg[0 +: dct_pkg::SYNC_STAGES-1], on_req};  // see (R26)
				off_pipe_reg <= {off_pipe_reg[0 +: dct_pkg::SYNC_STAGES-1], 1'b0};   // see (R26)
			end else begin
				on_pipe_reg[0] <= on_pipe_reg[0] || on_req;
			end
		end

		// Run state, start value and down counter.
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				state_reg <= dct_pkg::DCT_CH_IDLE;
				div_reg   <= dct_pkg::PR_RESET;
				load_reg  <= dct_pkg::CNT_RESET;
				pend_reg  <= 1'b0;
				live_reg  <= dct_pkg::CNT_RESET;
			end else if (soft_rst) begin
				state_reg <= dct_pkg::DCT_CH_IDLE;   // see (R23)
				div_reg   <= dct_pkg::PR_RESET;
				load_reg  <= dct_pkg::CNT_RESET;
				pend_reg  <= 1'b0;
				live_reg  <= dct_pkg::CNT_RESET;
			end else begin
				if (wr_div[z]) begin
					div_reg <= wd[dct_pkg::PR_WIDTH-1:0];
				end
				if (wr_cnt[z]) begin
					load_reg <= wd[15:0];
					pend_reg <= 1'b1;
				end
				case (state_reg)
					dct_pkg::DCT_CH_IDLE: begin
						if (on_take) begin
							state_reg <= dct_pkg::DCT_CH_RUN;
							// Without a fresh write the held count resumes.
							if (pend_reg) begin
								live_reg <= load_reg;            // see (R07) (R18)
								pend_reg <= 1'b0;
							end
						end
					end
					dct_pkg::DCT_CH_RUN: begin
						if (off_take) begin
							state_reg <= dct_pkg::DCT_CH_IDLE; // Count is kept, see (R07).
						end else if (zero_hit) begin
							live_reg <= reload ? load_reg : 16'h0000; // see (R10)
						end else if (ch_tick) begin
							live_reg <= live_reg - 16'h0001;   // see (R03)
						end
					end
					default: state_reg <= dct_pkg::DCT_CH_IDLE;
				endcase
			end
		end

		// Divider chain. Both stages clear while the channel is off, which is what the off
		// flag reports; a gated clock only freezes them.
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				first_reg  <= '0;
				second_reg <= '0;
			end else if (soft_rst || state_reg == dct_pkg::DCT_CH_IDLE) begin
				first_reg  <= '0;                      // see (R24)
				second_reg <= '0;
			end else begin
				if (active && !src_slow) begin
					first_reg <= first_reg + 16'h0001;   // see (R08)
				end
				if (active && s_in) begin
					second_reg <= second_reg + 15'h0001; // see (R15)
				end
			end
		end

		// Event flags; a setting event beats a clear in the same cycle.
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				done_pipe_reg <= '0;
				done_reg      <= 1'b0;
				off_reg       <= 1'b0;
				began_reg     <= 1'b0;
				on_reg        <= 1'b0;
			end else if (soft_rst) begin
				done_pipe_reg <= '0;
				done_reg      <= 1'b0;
				off_reg       <= 1'b0;
				began_reg     <= 1'b0;
				on_reg        <= 1'b0;
			end else begin
				if (clk_on_reg) begin
					done_pipe_reg <= {done_pipe_reg[0 +: dct_pkg::DONE_DELAY-1], zero_hit}; // see (R13)
				end
				done_reg  <= (clk_on_reg && done_pipe_reg[dct_pkg::DONE_DELAY-1])
				             || (done_reg && !clr_bits[DONE_F]);          // see (R12) (R13)
				off_reg   <= (off_take && state_reg == dct_pkg::DCT_CH_RUN)
				             || (off_reg && !clr_bits[OFF_F]);            // see (R12) (R24)
				began_reg <= (on_take && state_reg == dct_pkg::DCT_CH_IDLE)
				             || (began_reg && !clr_bits[BEGAN_F]);        // see (R12) (R18)
				if (on_take && state_reg == dct_pkg::DCT_CH_IDLE) begin
					on_reg <= 1'b1;                      // see (R19)
				end else if (off_take) begin
					on_reg <= 1'b0;
				end
			end
		end
	end

	// Slow clock synchroniser; only the second and third stages are looked at.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_sync_reg <= 3'h0;
		end else begin
			aux_sync_reg <= {aux_sync_reg[1:0], slow_aux_clock};
		end
	end

	// Power manager gate, mask and interrupt line.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_on_reg <= 1'b0;
			mask_reg   <= dct_pkg::MASK_RESET;
			irq_reg    <= 1'b0;
		end else begin
			if (wr_pon && wd[dct_pkg::PM_CLK_BIT]) begin
				clk_on_reg <= 1'b1;                      // see (R14)
			end else if (wr_poff && wd[dct_pkg::PM_CLK_BIT]) begin
				clk_on_reg <= 1'b0;                      // see (R14)
			end
			if (soft_rst) begin
				mask_reg <= dct_pkg::MASK_RESET;         // see (R23)
			end else if (wr_ien) begin
				mask_reg <= mask_reg | wd[dct_pkg::SR_FLAGS-1:0];  // see (R21)
			end else if (wr_idis) begin
				mask_reg <= mask_reg & ~wd[dct_pkg::SR_FLAGS-1:0];
			end
			irq_reg <= |(flags & mask_reg);              // see (R25)
		end
	end

	// Read decode.
	wire [31:0] stat_word = ({{(32 - dct_pkg::SR_FLAGS){1'b0}}, flags})
	                        | (32'(ch_on) << dct_pkg::SR_ON_BIT0);
	wire [31:0] rd_word =
		(s_axi_araddr == dct_pkg::OFF_STAT)  ? stat_word :
		(s_axi_araddr == dct_pkg::OFF_IMASK) ? {{(32 - dct_pkg::SR_FLAGS){1'b0}}, mask_reg} :
		(s_axi_araddr == dct_pkg::OFF_PMSR)  ? (32'(clk_on_reg) << dct_pkg::PM_CLK_BIT) :
		ra_div_hit[0]  ? {{(32 - dct_pkg::PR_WIDTH){1'b0}}, ch_div[0]} :
		ra_div_hit[1]  ? {{(32 - dct_pkg::PR_WIDTH){1'b0}}, ch_div[1]} :
		ra_cnt_hit[0]  ? {16'h0000, ch_load[0]} :
		ra_cnt_hit[1]  ? {16'h0000, ch_load[1]} :
		ra_live_hit[0] ? {16'h0000, ch_live[0]} :
		ra_live_hit[1] ? {16'h0000, ch_live[1]} : 32'h00000000;
	// Write-only registers read as zero with OKAY.
	wire rd_mapped = (s_axi_araddr == dct_pkg::OFF_STAT) || (s_axi_araddr == dct_pkg::OFF_IMASK)
		|| (s_axi_araddr == dct_pkg::OFF_PMSR) || (s_axi_araddr == dct_pkg::OFF_CTRL)
		|| (s_axi_araddr == dct_pkg::OFF_CLR) || (s_axi_araddr == dct_pkg::OFF_IEN)
		|| (s_axi_araddr == dct_pkg::OFF_IDIS) || (s_axi_araddr == dct_pkg::OFF_CLK_ON)
		|| (s_axi_araddr == dct_pkg::OFF_CLK_OFF)
		|| (|ra_div_hit) || (|ra_cnt_hit) || (|ra_live_hit);
	wire wr_mapped = (wa == dct_pkg::OFF_STAT) || (wa == dct_pkg::OFF_IMASK)
		|| (wa == dct_pkg::OFF_PMSR) || (wa == dct_pkg::OFF_CTRL) || (wa == dct_pkg::OFF_CLR)
		|| (wa == dct_pkg::OFF_IEN) || (wa == dct_pkg::OFF_IDIS) || (wa == dct_pkg::OFF_CLK_ON)
		|| (wa == dct_pkg::OFF_CLK_OFF) || (|wa_div_hit) || (|wa_cnt_hit);

	// Write channel: address and data are taken together, one write in flight.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_rdy_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg  <= dct_pkg::RESP_OKAY;
		end else begin
			aw_rdy_reg <= s_axi_awvalid && s_axi_wvalid && !aw_rdy_reg && !bvalid_reg;
			if (aw_rdy_reg) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_mapped ? dct_pkg::RESP_OKAY : dct_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read channel: data is registered in the cycle the address is taken.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg  <= dct_pkg::RESP_OKAY;
			rdata_reg  <= 32'h00000000;
		end else begin
			ar_rdy_reg <= s_axi_arvalid && !ar_rdy_reg && !rvalid_reg;
			if (ar_rdy_reg) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_word;
				rresp_reg  <= rd_mapped ? dct_pkg::RESP_OKAY : dct_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_awready = aw_rdy_reg;
	assign s_axi_wready  = aw_rdy_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = ar_rdy_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign irq           = irq_reg;
endmodule

// [bench/dct_timer_properties.sv]
/* Bus handshake properties of dct_timer, bound into every instance.
   Assumes the port names and widths that dct_timer declares. */
`timescale 1ns/1ps
module dct_timer_properties (
	input wire logic        ref_clk,
	input wire logic        rst_n,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	// One clock domain, so clock and reset are given once.
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// A register write is offered whole and then taken.
	sequence s_wr_take;
		s_axi_awvalid && s_axi_wvalid ##1 s_axi_awready;
	endsequence
	// A register read is offered and then taken.
	sequence s_rd_take;
		s_axi_arvalid ##1 s_axi_arready;
	endsequence
	a_wr_pair: assert property (s_axi_awready == s_axi_wready)
		else $error("awready and wready differ");
	a_wr_resp: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("write response missing");
	a_wr_cause: assert property (s_axi_awready |-> $past(s_axi_awvalid && s_axi_wvalid))
		else $error("write taken without request");
	a_wr_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rd_cause: assert property (s_axi_arready |-> $past(s_axi_arvalid))
		else $error("read taken without request");
	a_rd_resp: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read data missing");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule
bind dct_timer dct_timer_properties u_props (.ref_clk(ref_clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// [bench/testbench.sv]
/* Self-checking bench that drives dct_timer as an AXI4-Lite master.
   Assumes the design and its bound properties are compiled first. */
`timescale 1ns/1ps
module testbench;
	logic        clk, rst_n, slow, awv, wv, brdy, arv, rrdy, awr, wrd, bv, arr, rv, irq;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdd, v, w;
	logic [1:0]  br, rr;
	int          n_mismatch, total_checks, c;
	dct_timer uut (.ref_clk(clk), .rst_n(rst_n), .slow_aux_clock(slow),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
		.s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
		.s_axi_rready(rrdy), .irq(irq));
	// Core clock of 100 ns, and a slow clock of 800 ns off the rising core edges.
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		slow = 1'b0;
		forever #400 slow = ~slow;
	end
	task print_verdict;
		if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t value %h expected %h", $time, g, e);
		end
	endtask
	task chk_resp(input logic [1:0] g, input logic [1:0] e);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t response %h expected %h", $time, g, e);
		end
	endtask
	// Address and data are held until awready, a read address until arready; a spare edge ends every access.
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do @(posedge clk); while (awr !== 1'b1);
		awv <= 1'b0;
		wv <= 1'b0;
		// A late bready keeps the response waiting for one cycle.
		@(posedge clk);
		brdy <= 1'b1;
		do @(posedge clk); while (bv !== 1'b1);
		brdy <= 1'b0;
		chk_resp(br, e);
		@(posedge clk);
	endtask
	task rd(input logic [11:0] a, input logic [1:0] e);
		ara <= a;
		arv <= 1'b1;
		do @(posedge clk); while (arr !== 1'b1);
		arv <= 1'b0;
		// A late rready keeps the read data waiting for one cycle.
		@(posedge clk);
		rrdy <= 1'b1;
		do @(posedge clk); while (rv !== 1'b1);
		v = rdd;
		rrdy <= 1'b0;
		chk_resp(rr, e);
		@(posedge clk);
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		rd(a, 2'h0);
		chk(v, e);
	endtask
	// Polls the status register until one flag is up; the watchdog bounds the wait.
	task wst(input int b);
		do rd(12'h070, 2'h0); while (v[b] !== 1'b1);
	endtask
	// The watchdog bounds every wait on the design.
	task wirq;
		c = 0;
		while (irq !== 1'b1) begin
			@(posedge clk);
			c++;
		end
	endtask
	initial begin
		#2000000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		{rst_n, awv, wv, brdy, arv, rrdy, awa, ara, wd} = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc(12'h070, 32'h0);
		rc(12'h084, 32'h0);
		rd(12'h100, 2'h2);
		chk(v, 32'h0);
		wr(12'h100, 32'h1, 2'h2);
		wr(12'h050, 32'h2, 2'h0);
		rc(12'h058, 32'h2);
		wr(12'h074, 32'h3F, 2'h0);
		wr(12'h078, 32'h3E, 2'h0);
		rc(12'h07C, 32'h1);
		wr(12'h080, 32'h0, 2'h0);
		wr(12'h084, 32'h14, 2'h0);
		wr(12'h060, 32'h2, 2'h0);
		wirq();
		chk(32'(c >= 38 && c <= 52), 32'h1);
		rc(12'h070, 32'h01000005);
		rc(12'h200, 32'h0);
		wr(12'h084, 32'h1234, 2'h0);
		rc(12'h084, 32'h14);
		wr(12'h06C, 32'h3F, 2'h0);
		rc(12'h070, 32'h01000000);
		chk({31'h0, irq}, 32'h0);
		wr(12'h060, 32'h6, 2'h0);
		rc(12'h070, 32'h2);
		wr(12'h06C, 32'h3F, 2'h0);
		wr(12'h080, 32'h200, 2'h0);
		wr(12'h084, 32'h8, 2'h0);
		wr(12'h060, 32'h2, 2'h0);
		wirq();
		wr(12'h06C, 32'h1, 2'h0);
		wirq();
		chk(32'(c > 4 && c < 30), 32'h1);
		wr(12'h060, 32'h4, 2'h0);
		wr(12'h088, 32'h102, 2'h0);
		wr(12'h08C, 32'h64, 2'h0);
		wr(12'h060, 32'h8, 2'h0);
		repeat (400) @(posedge clk);
		wr(12'h060, 32'h10, 2'h0);
		wst(4);
		rd(12'h204, 2'h0);
		chk(32'(v > 82 && v < 92), 32'h1);
		w = v;
		repeat (200) @(posedge clk);
		rc(12'h204, w);
		wr(12'h060, 32'h8, 2'h0);
		wst(25);
		repeat (100) @(posedge clk);
		rd(12'h204, 2'h0);
		chk(32'(v < w && v + 8 > w), 32'h1);
		wr(12'h060, 32'h1, 2'h0);
		// Five slow clock periods of settling before the next access.
		repeat (40) @(posedge clk);
		rc(12'h080, 32'h0);
		rc(12'h07C, 32'h0);
		rc(12'h070, 32'h0);
		rc(12'h058, 32'h2);
		print_verdict();
	end
endmodule
